/* File: core/sd_chan_detect.sv */
// One switch channel: threshold comparator and transition detector.
// Assumes the voltage code is synchronous to i_clk.
`timescale 1ns/10ps
module sd_chan_detect
    import sd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_enable,
    input wire logic [SD_MV_W-1:0] i_input_mv,
    input wire logic [1:0] i_thr_sel,
    input wire logic [1:0] i_edge_sel,
    output logic o_level,
    output logic o_event
);

    typedef struct packed {
        logic level;
        logic armed;
        logic event_p;
    } sd_chan_s;

    sd_chan_s st;
    sd_chan_s next_st;
    logic [SD_MV_W-1:0] thr_mv;
    logic above;

    // ==================================================================
    // Threshold select, four fixed levels
    always_comb
    begin
        unique case (sd_thr_e'(i_thr_sel))
            SD_THR_2V0: thr_mv = SD_THR_2V0_MV;
            SD_THR_2V7: thr_mv = SD_THR_2V7_MV;
            SD_THR_3V0: thr_mv = SD_THR_3V0_MV;
            SD_THR_4V0: thr_mv = SD_THR_4V0_MV;
        endcase
        above = (i_input_mv > thr_mv);
    end

    // ==================================================================
    // Next state: sample level, flag a selected edge once armed
    always_comb
    begin
        next_st = st;
        next_st.event_p = 1'b0;
        if (i_run && i_enable)
        begin
            next_st.level = above;
            next_st.armed = 1'b1;
            if (st.armed && (above != st.level))
            begin
                if (above)
                begin
                    next_st.event_p = i_edge_sel[0];
                end
                else
                begin
                    next_st.event_p = i_edge_sel[1];
                end
            end
        end
        else
        begin
            next_st.level = 1'b0;
            next_st.armed = 1'b0; // First sample after start makes no edge
        end
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
    assign o_event = st.event_p;

endmodule // sd_chan_detect

/* File: core/sd_pkg.sv */
// Shared constants and types for the switch-detection front end.
// Assumes one 50 MHz clock domain; comparator inputs arrive as millivolt codes.
package sd_pkg;

    // ==================================================================
    // Sizes
    localparam int SD_CH_MAX = 24;     // Largest number of switch inputs
    localparam int SD_MV_W = 16;       // Width of an input voltage code
    localparam int SD_WET_W = 3;       // Width of a wetting-current code
    localparam int SD_CIE_W = 8;       // Width of the interrupt-enable word

    // ==================================================================
    // Configuration interrupt-enable word
    localparam logic [7:0] SD_CIE_OFFSET = 8'h24;   // Offset on the serial map
    localparam int SD_CIE_SSC_BIT = 2;              // State-change enable bit
    localparam logic [7:0] SD_CIE_RST = 8'h00;      // Reset value, all disabled

    // ==================================================================
    // Comparator thresholds in millivolts
    localparam logic [SD_MV_W-1:0] SD_THR_2V0_MV = 16'h07D0;
    localparam logic [SD_MV_W-1:0] SD_THR_2V7_MV = 16'h0A8C;
    localparam logic [SD_MV_W-1:0] SD_THR_3V0_MV = 16'h0BB8;
    localparam logic [SD_MV_W-1:0] SD_THR_4V0_MV = 16'h0FA0;

    // ==================================================================
    // Encodings
    typedef enum logic [1:0] {
        SD_THR_2V0 = 2'b00,
        SD_THR_2V7 = 2'b01,
        SD_THR_3V0 = 2'b10,
        SD_THR_4V0 = 2'b11
    } sd_thr_e;

    typedef enum logic [1:0] {
        SD_EDGE_NONE = 2'b00,
        SD_EDGE_RISE = 2'b01,
        SD_EDGE_FALL = 2'b10,
        SD_EDGE_BOTH = 2'b11
    } sd_edge_e;

    typedef enum logic [2:0] {
        SD_WET_0MA = 3'b000,
        SD_WET_1MA = 3'b001,
        SD_WET_2MA = 3'b010,
        SD_WET_5MA = 3'b011,
        SD_WET_10MA = 3'b100,
        SD_WET_15MA = 3'b101
    } sd_wet_e;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic poll_enable;        // 0 selects continuous mode
        logic trigger;            // One-cycle pulse, starts detection
        logic autoscale_disable;  // Stops wetting-current auto-scaling
        logic status_read;        // One-cycle pulse, host read of status
    } sd_ctrl_s;

    typedef struct packed {
        logic running;            // Detection started
        logic continuous;         // Wetting current supplied continuously
        logic autoscale_active;   // Auto-scaling of wetting current active
        logic ssc_flag;           // Switch-state-change status, sticky
    } sd_status_s;

    // ==================================================================
    // Reset values
    localparam logic SD_INT_N_RST = 1'b1;
    localparam sd_status_s SD_STATUS_RST = '0;

endpackage

/* File: core/sd_switch_detect.sv */
// Switch-detection front end: channel setup, wetting-current steering,
// comparator detection, sticky status and an active-low interrupt pin.
// Assumes all control ports are synchronous to i_clk and that the host
// pulses trigger and status_read for one cycle each.
//
// Notes on behaviour
// - Channel enable bit activates input monitoring.
// - Direction bit zero means sourcing wetting current.
// - Pair wetting code 100 selects 10 mA.
// - Auto-scale disable bit stops current auto-scaling.
// - Threshold code 11 selects four volts.
// - Exactly four thresholds: 2, 2.7, 3, 4 V.
// - Edge code 11 interrupts on both edges.
// - State-change enable lets events pull interrupt.
// - Polling disabled means continuous wetting current.
// - Trigger starts detection with current settings.
// - Start raises baseline interrupt; status read clears.
// - Switch transition asserts active-low interrupt output.
// - Status holds comparator state and interrupt flags; comparator state comes out on o_comp_state, not in o_status.
// - Edge codes: none, rising, falling, both.
// - State-change enable is bit 2, reset off.
`timescale 1ns/10ps
module sd_switch_detect
    import sd_pkg::*;
#(
    parameter int N_CH = SD_CH_MAX
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [N_CH-1:0] i_chan_enable,
    input wire logic [N_CH-1:0] i_chan_current_direction,
    input wire logic [N_CH/2-1:0][SD_WET_W-1:0] i_wetting_level,
    input wire logic [N_CH/4-1:0][1:0] i_threshold_sel,
    input wire logic [N_CH-1:0][1:0] i_edge_sel,
    input wire logic [SD_CIE_W-1:0] i_config_irq_enable_reg,
    input wire sd_ctrl_s i_ctrl,
    input wire logic [N_CH-1:0][SD_MV_W-1:0] i_input_mv,
    output logic o_int_n,
    output sd_status_s o_status,
    output logic [N_CH-1:0] o_chan_flags,
    output logic [N_CH-1:0] o_comp_state,
    output logic [N_CH-1:0] o_source_en,
    output logic [N_CH-1:0] o_sink_en,
    output logic [N_CH-1:0][SD_WET_W-1:0] o_wetting_code
);

    // ==================================================================
    // Elaboration check: channels come in groups of four
    if ((N_CH < 4) || (N_CH > SD_CH_MAX) || ((N_CH % 4) != 0))
    begin : g_bad_n_ch
        $error("N_CH must be a multiple of 4 between 4 and 24");
    end

    // ==================================================================
    // State of the block
    typedef struct packed {
        logic int_n;
        sd_status_s status;
        logic [N_CH-1:0] chan_flags;
        logic [N_CH-1:0] source_en;
        logic [N_CH-1:0] sink_en;
        logic [N_CH-1:0][SD_WET_W-1:0] wetting_code;
    } sd_top_s;

    sd_top_s st;
    sd_top_s next_st;
    logic [N_CH-1:0] chan_event;
    logic [N_CH-1:0] chan_level;
    logic ssc_enable;
    logic current_on;

    // ==================================================================
    // Per-channel comparators and transition detectors
    for (genvar ch = 0; ch < N_CH; ch++)
    begin : g_chan
        sd_chan_detect u_chan (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_run(st.status.running),
            .i_enable(i_chan_enable[ch]),
            .i_input_mv(i_input_mv[ch]),
            .i_thr_sel(i_threshold_sel[ch/4]),
            .i_edge_sel(i_edge_sel[ch]),
            .o_level(chan_level[ch]),
            .o_event(chan_event[ch])
        );
    end

    // Interrupt gate and continuous-mode current supply
    assign ssc_enable = i_config_irq_enable_reg[SD_CIE_SSC_BIT];
    assign current_on = st.status.running && !i_ctrl.poll_enable;

    // ==================================================================
    // Next-state logic
    always_comb
    begin
        next_st = st;

        // Start of detection, latched until reset
        if (i_ctrl.trigger)
        begin
            next_st.status.running = 1'b1;
        end
        next_st.status.continuous = current_on;
        next_st.status.autoscale_active = current_on && !i_ctrl.autoscale_disable;

        // Host read clears sticky status; a new event in the same cycle wins
        if (i_ctrl.status_read)
        begin
            next_st.status.ssc_flag = 1'b0;
            next_st.chan_flags = '0;
        end
        next_st.chan_flags = next_st.chan_flags | chan_event;
        if ((i_ctrl.trigger && !st.status.running) || (|chan_event))
        begin
            next_st.status.ssc_flag = 1'b1;
        end

        // Pin pulled low while an enabled state change is pending
        next_st.int_n = !(next_st.status.ssc_flag && ssc_enable);

        // Wetting-current steering per channel
        for (int ch = 0; ch < N_CH; ch++)
        begin
            next_st.source_en[ch] = current_on && i_chan_enable[ch]
                && !i_chan_current_direction[ch];
            next_st.sink_en[ch] = current_on && i_chan_enable[ch]
                && i_chan_current_direction[ch];
            if (i_wetting_level[ch/2] > SD_WET_15MA)
            begin
                next_st.wetting_code[ch] = SD_WET_0MA; // Unused codes: current off
            end
            else
            begin
                next_st.wetting_code[ch] = i_wetting_level[ch/2];
            end
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '0;
            st.int_n <= SD_INT_N_RST;
            st.status <= SD_STATUS_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==================================================================
    // Outputs, all straight from the state register or channel flops
    assign o_int_n = st.int_n;
    assign o_status = st.status;
    assign o_chan_flags = st.chan_flags;
    assign o_comp_state = chan_level;
    assign o_source_en = st.source_en;
    assign o_sink_en = st.sink_en;
    assign o_wetting_code = st.wetting_code;

endmodule // sd_switch_detect

/* File: verif/sd_host_model.sv */
// Host model: answers a low interrupt pin with one status read pulse.
// Assumes the pin is registered on the rising edge of i_clk.
`timescale 1ns/10ps
module sd_host_model
(
    input wire logic i_clk,
    input wire logic i_active,
    input wire logic [3:0] i_delay,
    input wire logic i_int_n,
    output logic o_status_read
);
    logic [3:0] wait_cnt;
    initial o_status_read = 1'b0;
    initial wait_cnt = 4'h0;
    // Read once the pin has been low for i_delay cycles
    always @(negedge i_clk)
    begin
        if (o_status_read || !i_active || i_int_n)
        begin
            o_status_read <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else if (wait_cnt >= i_delay)
            o_status_read <= 1'b1;
        else
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule // sd_host_model

/* File: verif/sd_switch_detect_bench.sv */
// Testbench of the switch-detection front end with a host model.
// Inputs change at the falling edge; four channels.
`timescale 1ns/10ps
module sd_switch_detect_bench
    import sd_pkg::*;
;
    localparam int NC = 4;
    logic i_clk, i_rst, poll, trig, asd, b_rd, h_rd, h_on, o_int_n;
    logic [3:0] h_dly;
    logic [NC-1:0] en, dir, flg, cmp, src, snk;
    logic [NC/2-1:0][2:0] wet;
    logic [0:0][1:0] thr;
    logic [NC-1:0][1:0] edg;
    logic [7:0] cie;
    logic [NC-1:0][15:0] mv;
    logic [NC-1:0][2:0] wc;
    logic [15:0] tab [4];
    sd_status_s st;
    sd_ctrl_s ctl;
    int n_mismatch = 0;
    int checks_done = 0;
    assign ctl = '{poll, trig, asd, b_rd | h_rd};
    sd_switch_detect #(.N_CH(NC)) dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_chan_enable(en), .i_chan_current_direction(dir), .i_wetting_level(wet),
        .i_threshold_sel(thr), .i_edge_sel(edg), .i_config_irq_enable_reg(cie),
        .i_ctrl(ctl), .i_input_mv(mv), .o_int_n(o_int_n), .o_status(st),
        .o_chan_flags(flg), .o_comp_state(cmp), .o_source_en(src),
        .o_sink_en(snk), .o_wetting_code(wc));
    sd_host_model host (.i_clk(i_clk), .i_active(h_on), .i_delay(h_dly),
        .i_int_n(o_int_n), .o_status_read(h_rd));
    // ==================================================================
    // Clock and helpers
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            n_mismatch++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_pin(input logic lvl);
        for (int i = 0; i < 50 && o_int_n !== lvl; i++) step(1);
        if (o_int_n !== lvl)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic clear();
        b_rd = 1'b1;
        step(1);
        b_rd = 1'b0;
        step(1);
    endtask
    // ==================================================================
    // Main sequence
    initial
    begin
        tab = '{SD_THR_2V0_MV, SD_THR_2V7_MV, SD_THR_3V0_MV, SD_THR_4V0_MV};
        {i_rst, poll, trig, asd, b_rd, h_on, h_dly} = {6'h21, 4'h3};
        {en, dir, wet, thr, edg, cie, mv} = '0;
        repeat (2) @(posedge i_clk);
        step(1);
        i_rst = 1'b0;
        check("int_n", o_int_n, 1'b1);
        check("status", st, SD_STATUS_RST);
        $display("test reset done");
        // Full setup before the trigger
        {en, asd, cie[SD_CIE_SSC_BIT]} = {4'h1, 2'h3};
        {wet[0], thr[0], edg[0]} = {SD_WET_10MA, SD_THR_4V0, SD_EDGE_BOTH};
        {mv[0], mv[1]} = {16'h1388, 16'h1388};
        trig = 1'b1;
        step(1);
        trig = 1'b0;
        check("start", {st.running, st.ssc_flag, o_int_n}, 3'h6);
        step(1);
        check("cont", st.continuous, 1'b1);
        check("dir", {src[0], snk[0]}, 2'h2);
        check("wet", wc[0], SD_WET_10MA);
        check("scale", st.autoscale_active, 1'b0);
        check("cmp", cmp[1:0], 2'h1);
        wait_pin(1'b1);
        check("ssc", st.ssc_flag, 1'b0);
        $display("test start done");
        h_dly = 4'h0;
        mv[0] = 16'h03E8;
        wait_pin(1'b0);
        check("event", {flg[0], cmp[0], st.ssc_flag}, 3'h5);
        wait_pin(1'b1);
        check("cleared", flg[0], 1'b0);
        $display("test switch done");
        h_on = 1'b0;
        for (int c = 0; c < 5; c++)
        begin
            edg[0] = (c < 4) ? 2'(c) : SD_EDGE_BOTH; // Last pass: both edges, pin gated off
            cie[SD_CIE_SSC_BIT] = (c < 4);
            clear();
            mv[0] = 16'h1388;
            step(3);
            check("rise", {flg[0], o_int_n}, {edg[0][0], !(edg[0][0] && c < 4)});
            clear();
            mv[0] = 16'h03E8;
            step(3);
            check("fall", flg[0], edg[0][1]);
        end
        $display("test edges done");
        for (int k = 0; k < 4; k++)
        begin
            thr[0] = 2'(k);
            mv[0] = tab[k];
            step(2);
            check("at thr", cmp[0], 1'b0);
            mv[0] = tab[k] + 16'h0001;
            step(2);
            check("above thr", cmp[0], 1'b1);
        end
        $display("test thresholds done");
        {asd, dir[0], wet[0]} = {2'h1, 3'h6};
        step(2);
        check("scale on", st.autoscale_active, 1'b1);
        check("sink", {src[0], snk[0]}, 2'h1);
        check("wet off", wc[0], SD_WET_0MA);
        $display("test steering done");
        poll = 1'b1;
        step(2);
        check("poll", {st.continuous, src[0]}, 2'h0);
        $display("test poll done");
        report_and_stop();
    end
endmodule // sd_switch_detect_bench

/* File: verif/sd_switch_detect_chk.sv */
// Checker for the switch-detection front end, bound to its top module.
// Sees the top module ports only; one clock, async reset.
`timescale 1ns/10ps
module sd_switch_detect_chk
    import sd_pkg::*;
#(
    parameter int N_CH = SD_CH_MAX
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [N_CH-1:0] i_chan_enable,
    input wire logic [N_CH-1:0] i_chan_current_direction,
    input wire logic [N_CH/2-1:0][SD_WET_W-1:0] i_wetting_level,
    input wire logic [N_CH/4-1:0][1:0] i_threshold_sel,
    input wire logic [N_CH-1:0][1:0] i_edge_sel,
    input wire logic [SD_CIE_W-1:0] i_config_irq_enable_reg,
    input wire sd_ctrl_s i_ctrl,
    input wire logic [N_CH-1:0][SD_MV_W-1:0] i_input_mv,
    input wire logic o_int_n,
    input wire sd_status_s o_status,
    input wire logic [N_CH-1:0] o_chan_flags,
    input wire logic [N_CH-1:0] o_comp_state,
    input wire logic [N_CH-1:0] o_source_en,
    input wire logic [N_CH-1:0] o_sink_en,
    input wire logic [N_CH-1:0][SD_WET_W-1:0] o_wetting_code
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==================================================================
    // Interrupt, status and channel relations
    a_pin_has_flag: assert property (!o_int_n |-> o_status.ssc_flag)
        else $error("pin low with no flag");
    a_pin_enabled: assert property (o_status.ssc_flag && !i_ctrl.status_read
        && i_config_irq_enable_reg[SD_CIE_SSC_BIT] |=> !o_int_n)
        else $error("enabled flag does not pull pin");
    a_trigger_start: assert property (i_ctrl.trigger && !o_status.running
        |=> o_status.running && o_status.ssc_flag)
        else $error("trigger gave no start");
    a_read_clears: assert property (i_ctrl.status_read && o_status.running
        && !i_ctrl.trigger && $stable(o_comp_state) |=> !o_status.ssc_flag)
        else $error("read left flag set");
    a_cont_mode: assert property (o_status.running && !i_ctrl.poll_enable
        |=> o_status.continuous)
        else $error("no continuous mode");
    a_auto_scale: assert property (o_status.running && !i_ctrl.poll_enable
        |=> o_status.autoscale_active == !$past(i_ctrl.autoscale_disable))
        else $error("auto-scale wrong");
    a_source_dir: assert property (o_status.running && !i_ctrl.poll_enable
        && i_chan_enable[0] && !i_chan_current_direction[0]
        |=> o_source_en[0] && !o_sink_en[0])
        else $error("channel not sourcing");
    a_wet_level: assert property (o_status.running && !i_ctrl.poll_enable
        && i_chan_enable[0] && i_wetting_level[0] == SD_WET_10MA
        |=> o_wetting_code[0] == SD_WET_10MA)
        else $error("wetting code wrong");
    a_comp_high: assert property (o_status.running && i_chan_enable[0]
        && i_threshold_sel[0] == SD_THR_4V0 && i_input_mv[0] > SD_THR_4V0_MV
        |=> o_comp_state[0])
        else $error("comparator missed high input");
    a_edge_none: assert property ($rose(o_chan_flags[0])
        |-> $past(i_edge_sel[0], 2) != SD_EDGE_NONE)
        else $error("flag with edges off");
    a_chan_off: assert property (!i_chan_enable[1] |=> !o_comp_state[1])
        else $error("disabled channel compares");
    c_start: cover property (i_ctrl.trigger ##1 o_status.running);
    c_pin: cover property ($fell(o_int_n));
    c_flag: cover property ($rose(o_chan_flags[0]));
endmodule // sd_switch_detect_chk

bind sd_switch_detect sd_switch_detect_chk #(.N_CH(N_CH)) u_chk (.*);
